// ### sfp_space.sv
// paged special function register decoder with timed-access page select
`timescale 1ns/100ps
`include "sfp_defines.svh"
module sfp_space (
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       direct_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic       bit_in,
  input  wire logic [2:0] bit_sel_in,
  input  wire logic       bit_val_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic [7:0] spi_flags_set_in,
  input  wire logic [7:0] ext_rd_data_in,
  output logic      [7:0] rd_data_out,
  output logic            bit_rd_out,
  output logic            rd_valid_out,
  output logic            page_out,
  output logic            bit_refused_out,
  output logic            reserved_hit_out,
  output logic            ext_rd_out,
  output logic            ext_wr_out,
  output logic            ext_bit_out,
  output logic      [7:0] ext_addr_out,
  output logic            ext_page_out,
  output logic      [7:0] ext_wdata_out,
  output logic      [2:0] ext_bit_sel_out,
  output logic            ext_bit_val_out,
  output logic      [7:0] spi_control_out,
  output logic      [7:0] spi_control_ext_out,
  output logic      [7:0] spi_flags_out,
  output logic      [7:0] spi_data_buf_out,
  output logic      [7:0] analog_digital_input_disable_out,
  output logic      [7:0] irq_priority_high_ext_out,
  output logic      [7:0] serial1_control_out,
  output logic      [7:0] pwm_deadtime_enable_out,
  output logic      [7:0] pwm_deadtime_count_out,
  output logic      [7:0] pwm_mask_enable_out,
  output logic      [7:0] pwm_mask_data_out,
  output logic      [7:0] irq_priority_ext1_out,
  output logic      [7:0] irq_priority_high_ext1_out
);

  // locally held registers, index order fixed by the lookup below
  logic [7:0] regs [0:`SFP_REG_COUNT-1];

  logic             page_choice_bit;
  sfp_pkg::sfp_key_t key_state;

  // decode of the current request
  logic             hit;
  logic             bit_ok;
  logic             refused;
  logic             resv;
  logic             acc;
  logic             loc_hit;
  sfp_pkg::sfp_idx_t loc_idx;
  logic             is_page;
  logic             is_key;
  logic             ext_sel;

  // first read stage
  logic             s1_rd;
  logic             s1_bit;
  logic             s1_local;
  logic [7:0]       s1_data;
  logic [2:0]       s1_sel;

  // local register lookup, banked only where the map says so
  function automatic logic [4:0] lookup(input logic [7:0] a,
                                        input logic       p);
    logic [4:0] r;
    r = 5'h00;
    case (a)
      `SFP_SPI_CTRL_ADDR: r = p ? 5'h11 : 5'h10;
      `SFP_SPI_FLAG_ADDR: r = 5'h12;
      `SFP_SPI_DATA_ADDR: r = p ? 5'h00 : 5'h13;
      `SFP_AIN_DIS_ADDR:  r = p ? 5'h00 : 5'h14;
      `SFP_IRQ_PH_ADDR:   r = p ? 5'h00 : 5'h15;
      `SFP_SER1_ADDR:     r = 5'h16;
      `SFP_PDT_EN_ADDR:   r = 5'h17;
      `SFP_PDT_CNT_ADDR:  r = 5'h18;
      `SFP_PM_EN_ADDR:    r = 5'h19;
      `SFP_PM_DATA_ADDR:  r = 5'h1a;
      `SFP_IRQ_P1_ADDR:   r = p ? 5'h00 : 5'h1b;
      `SFP_IRQ_PH1_ADDR:  r = p ? 5'h00 : 5'h1c;
      default:            r = 5'h00;
    endcase
    return r;
  endfunction

  // unoccupied locations on each page
  function automatic logic reserved(input logic [7:0] a,
                                    input logic       p);
    logic r;
    r = 1'b0;
    case (a)
      8'h9d, 8'h9e, 8'ha1, 8'hb6: r = 1'b1;
      8'hef, 8'hf5, 8'hf6, 8'hf7: r = p;
      8'hfd, 8'hfe, 8'hff:        r = p;
      default:                    r = 1'b0;
    endcase
    return r;
  endfunction

  // replace one bit of a byte
  function automatic logic [7:0] put_bit(input logic [7:0] v,
                                         input logic [2:0] s,
                                         input logic       b);
    logic [7:0] r;
    r = v;
    r[s] = b;
    return r;
  endfunction

  // request decode
  assign hit     = direct_in & sfr_addr_in[`SFP_SPACE_MSB]
                 & (rd_in | wr_in);
  assign bit_ok  = (sfr_addr_in[2:0] == 3'h0);
  assign refused = hit & bit_in & ~bit_ok;
  assign resv    = hit & reserved(sfr_addr_in, page_choice_bit);
  assign acc     = hit & ~refused & ~resv;
  assign loc_hit = lookup(sfr_addr_in, page_choice_bit) != 5'h00;
  // low four bits of the lookup code are the array index
  assign loc_idx = 4'(lookup(sfr_addr_in, page_choice_bit));
  assign is_page = sfr_addr_in == `SFP_PAGE_SEL_ADDR;
  assign is_key  = sfr_addr_in == `SFP_KEY_ADDR;
  assign ext_sel = acc & ~loc_hit & ~is_page & ~is_key;

  // timed-access unlock sequence
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      key_state <= sfp_pkg::SFP_KEY_IDLE;
    end else if (acc & wr_in & is_key & ~bit_in) begin
      case (key_state)
        sfp_pkg::SFP_KEY_IDLE:
          key_state <= (wdata_in == `SFP_KEY_FIRST)
                     ? sfp_pkg::SFP_KEY_FIRST
                     : sfp_pkg::SFP_KEY_IDLE;
        sfp_pkg::SFP_KEY_FIRST:
          key_state <= (wdata_in == `SFP_KEY_SECOND)
                     ? sfp_pkg::SFP_KEY_OPEN
                     : (wdata_in == `SFP_KEY_FIRST)
                     ? sfp_pkg::SFP_KEY_FIRST
                     : sfp_pkg::SFP_KEY_IDLE;
        default:
          key_state <= (wdata_in == `SFP_KEY_FIRST)
                     ? sfp_pkg::SFP_KEY_FIRST
                     : sfp_pkg::SFP_KEY_IDLE;
      endcase
    end else if (hit) begin
      key_state <= sfp_pkg::SFP_KEY_IDLE;   // any other access relocks
    end
  end

  // page selector, written only straight after the unlock
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      page_choice_bit <= `SFP_PAGE_SEL_RST;
    end else if (acc & wr_in & is_page & ~bit_in &
                 (key_state == sfp_pkg::SFP_KEY_OPEN)) begin
      page_choice_bit <= wdata_in[`SFP_PAGE_BIT];
    end
  end

  // local registers; spi flag set by hardware wins over a write
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < `SFP_REG_COUNT; i++) begin
        regs[i] <= `SFP_REG_RST;
      end
    end else begin
      for (int i = 0; i < `SFP_REG_COUNT; i++) begin
        if (acc & wr_in & loc_hit & (loc_idx == 4'(i))) begin
          regs[i] <= bit_in
                   ? put_bit(regs[i], bit_sel_in, bit_val_in)
                   : wdata_in;
        end
      end
      if (acc & wr_in & loc_hit & (loc_idx == 4'h2)) begin
        regs[2] <= (wdata_in | spi_flags_set_in) & `SFP_SPI_FLAG_MASK;
      end else begin
        regs[2] <= (regs[2] | spi_flags_set_in) & `SFP_SPI_FLAG_MASK;
      end
    end
  end

  // forward of shared registers held elsewhere
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      ext_rd_out      <= 1'b0;
      ext_wr_out      <= 1'b0;
      ext_bit_out     <= 1'b0;
      ext_addr_out    <= 8'h00;
      ext_page_out    <= 1'b0;
      ext_wdata_out   <= 8'h00;
      ext_bit_sel_out <= 3'h0;
      ext_bit_val_out <= 1'b0;
    end else begin
      ext_rd_out      <= ext_sel & rd_in;
      ext_wr_out      <= ext_sel & wr_in;
      ext_bit_out     <= ext_sel & bit_in;
      if (ext_sel) begin
        ext_addr_out    <= sfr_addr_in;
        ext_page_out    <= page_choice_bit;
        ext_wdata_out   <= wdata_in;
        ext_bit_sel_out <= bit_sel_in;
        ext_bit_val_out <= bit_val_in;
      end
    end
  end

  // first read stage: capture local value or wait for forward
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s1_rd    <= 1'b0;
      s1_bit   <= 1'b0;
      s1_local <= 1'b0;
      s1_data  <= 8'h00;
      s1_sel   <= 3'h0;
    end else begin
      s1_rd    <= hit & rd_in;
      s1_bit   <= bit_in;
      s1_local <= ~ext_sel;
      s1_sel   <= bit_sel_in;
      if (~acc) begin
        s1_data <= 8'h00;             // refused or unoccupied: zero
      end else if (is_page) begin
        s1_data <= {7'h00, page_choice_bit};
      end else if (loc_hit) begin
        s1_data <= regs[loc_idx];
      end else begin
        s1_data <= 8'h00;             // key register reads as zero
      end
    end
  end

  // second read stage, answer to the core
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 8'h00;
      bit_rd_out   <= 1'b0;
    end else begin
      rd_valid_out <= s1_rd;
      if (s1_rd) begin
        rd_data_out <= s1_local ? s1_data : ext_rd_data_in;
        bit_rd_out  <= s1_bit &
                       (s1_local ? s1_data[s1_sel]
                                 : ext_rd_data_in[s1_sel]);
      end
    end
  end

  // error pulses for refused bit access and unoccupied locations
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      bit_refused_out  <= 1'b0;
      reserved_hit_out <= 1'b0;
    end else begin
      bit_refused_out  <= refused;
      reserved_hit_out <= resv & ~refused;
    end
  end

  // register contents toward the peripherals
  assign page_out                         = page_choice_bit;
  assign spi_control_out                  = regs[0];
  assign spi_control_ext_out              = regs[1];
  assign spi_flags_out                    = regs[2];
  assign spi_data_buf_out                 = regs[3];
  assign analog_digital_input_disable_out = regs[4];
  assign irq_priority_high_ext_out        = regs[5];
  assign serial1_control_out              = regs[6];
  assign pwm_deadtime_enable_out          = regs[7];
  assign pwm_deadtime_count_out           = regs[8];
  assign pwm_mask_enable_out              = regs[9];
  assign pwm_mask_data_out                = regs[10];
  assign irq_priority_ext1_out            = regs[11];
  assign irq_priority_high_ext1_out       = regs[12];

endmodule

// ### sfp_defines.svh
// constants of the paged special function register space
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_SPACE_MSB      7
`define SFP_PAGE_SEL_ADDR  8'h91
`define SFP_KEY_ADDR       8'hc7
`define SFP_KEY_FIRST      8'haa
`define SFP_KEY_SECOND     8'h55
`define SFP_PAGE_SEL_RST   1'b0
`define SFP_PAGE_BIT       0
`define SFP_SPI_CTRL_ADDR  8'hf3
`define SFP_SPI_FLAG_ADDR  8'hf4
`define SFP_SPI_DATA_ADDR  8'hf5
`define SFP_AIN_DIS_ADDR   8'hf6
`define SFP_IRQ_PH_ADDR    8'hf7
`define SFP_SER1_ADDR      8'hf8
`define SFP_PDT_EN_ADDR    8'hf9
`define SFP_PDT_CNT_ADDR   8'hfa
`define SFP_PM_EN_ADDR     8'hfb
`define SFP_PM_DATA_ADDR   8'hfc
`define SFP_PORDIS_ADDR    8'hfd
`define SFP_IRQ_P1_ADDR    8'hfe
`define SFP_IRQ_PH1_ADDR   8'hff
`define SFP_REG_RST        8'h00
`define SFP_SPI_FLAG_MASK  8'hfc
`define SFP_REG_COUNT      13
`endif

// ### sfp_pkg.sv
// types of the paged special function register space
package sfp_pkg;
  // unlock sequence states, gray along idle, first key, open
  typedef enum logic [1:0] {
    SFP_KEY_IDLE  = 2'b00,
    SFP_KEY_FIRST = 2'b01,
    SFP_KEY_OPEN  = 2'b11
  } sfp_key_t;
  // index into the local register array
  typedef logic [3:0] sfp_idx_t;
endpackage

// ### sfp_space_sva.sv
// assertions on the ports of the paged register space
`timescale 1ns/100ps
module sfp_space_sva (
  input wire logic       mclk_in,
  input wire logic       rst_b_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       direct_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic       bit_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       rd_valid_out,
  input wire logic       page_out,
  input wire logic       bit_refused_out,
  input wire logic       reserved_hit_out,
  input wire logic       ext_rd_out,
  input wire logic       ext_wr_out,
  input wire logic [7:0] ext_addr_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // decoded request kinds
  wire logic rq   = direct_in & sfr_addr_in[7];
  wire logic rd_t = rq & rd_in;
  wire logic wb   = rq & wr_in & !bit_in;
  wire logic k1   = wb & (sfr_addr_in == 8'hc7) & (wdata_in == 8'haa);
  wire logic k2   = wb & (sfr_addr_in == 8'hc7) & (wdata_in == 8'h55);
  wire logic ps   = wb & (sfr_addr_in == 8'h91);
  wire logic wd0  = wdata_in[0];
  wire logic bref = rq & (rd_in | wr_in) & bit_in & (sfr_addr_in[2:0] != 3'h0);
  // key, key, selector write
  sequence s_unlock;
    k1 ##1 k2 ##1 ps;
  endsequence
  a_rd_valid: assert property (rd_t |-> ##2 rd_valid_out)
    else $error("read answer missing");
  a_not_taken: assert property ((rd_in | wr_in) & !rq |=>
    (!ext_rd_out && !ext_wr_out) ##1 !rd_valid_out)
    else $error("untaken request answered");
  a_reset_page: assert property ($rose(rst_b_in) |-> !page_out)
    else $error("page not zero after reset");
  a_sel_unlock: assert property (s_unlock |=> page_out == $past(wd0))
    else $error("unlocked selector write lost");
  a_sel_locked: assert property (
    ps & !($past(k2) & $past(k1, 2)) |=> $stable(page_out))
    else $error("locked selector write took effect");
  a_sel_read: assert property (rd_t & !wr_in & !bit_in &
    (sfr_addr_in == 8'h91) |-> ##2 rd_data_out == {7'h00, page_out})
    else $error("selector read wrong");
  a_bit_refuse: assert property (1'b1 |=> bit_refused_out == $past(bref))
    else $error("bit refusal wrong");
  a_reserved_hit: assert property (rd_t & !wr_in & !bit_in &
    (sfr_addr_in == 8'h9d) |=> reserved_hit_out ##1
    (rd_valid_out && rd_data_out == 8'h00))
    else $error("reserved read not flagged");
  a_ext_read: assert property (rd_t & (sfr_addr_in == 8'h80) |=>
    ext_rd_out && ext_addr_out == $past(sfr_addr_in))
    else $error("forwarded read missing");
endmodule
bind sfp_space sfp_space_sva u_sfp_space_sva (.mclk_in, .rst_b_in,
  .sfr_addr_in, .direct_in, .rd_in, .wr_in, .bit_in, .wdata_in,
  .rd_data_out, .rd_valid_out, .page_out, .bit_refused_out,
  .reserved_hit_out, .ext_rd_out, .ext_wr_out, .ext_addr_out);

// ### sfp_ext_model.sv
// model of the forwarded peripheral registers
`timescale 1ns/100ps
module sfp_ext_model (
  input  wire logic       mclk_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic       page_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [0:511];
  logic [7:0] last = 8'h00;
  // storage per page and address
  always_ff @(posedge mclk_in) begin
    if (wr_in)
      mem[{page_in, addr_in}] <= wdata_in;
    if (rd_in)
      last <= rdata_out;
  end
  // outside a read the bus shows no stale value
  assign rdata_out = rd_in ? mem[{page_in, addr_in}] : ~last;
endmodule

// ### sfp_space_tb.sv
// self-checking bench of the paged register space
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module sfp_space_tb;
  logic       mclk_in = 0, rst_b_in = 0, direct_in = 1, rd_in = 0, wr_in = 0;
  logic       bit_in = 0, bit_val_in = 0, bit_rd_out, rd_valid_out, page_out;
  logic       bit_refused_out, ext_rd_out, ext_wr_out, ext_page_out;
  logic [2:0] bit_sel_in = 0;
  logic [7:0] sfr_addr_in = 0, wdata_in = 0, rd_data_out, ext_addr_out;
  logic [7:0] ext_rd_data_in, ext_wdata_out, spi_control_ext_out;
  logic [7:0] mm [0:511];
  logic [31:0] s = 32'he4d4dc0c;
  logic       pg = 0;
  int         failures = 0, checks_done = 0;
  sfp_space u_sfp_space (.mclk_in, .rst_b_in, .sfr_addr_in, .direct_in,
    .rd_in, .wr_in, .bit_in, .bit_sel_in, .bit_val_in, .wdata_in,
    .spi_flags_set_in(8'h00), .ext_rd_data_in, .rd_data_out, .bit_rd_out,
    .rd_valid_out, .page_out, .bit_refused_out, .reserved_hit_out(),
    .ext_rd_out, .ext_wr_out, .ext_bit_out(), .ext_addr_out, .ext_page_out,
    .ext_wdata_out, .ext_bit_sel_out(), .ext_bit_val_out(),
    .spi_control_out(), .spi_control_ext_out, .spi_flags_out(),
    .spi_data_buf_out(), .analog_digital_input_disable_out(),
    .irq_priority_high_ext_out(), .serial1_control_out(),
    .pwm_deadtime_enable_out(), .pwm_deadtime_count_out(),
    .pwm_mask_enable_out(), .pwm_mask_data_out(), .irq_priority_ext1_out(),
    .irq_priority_high_ext1_out());
  sfp_ext_model u_sfp_ext_model (.mclk_in, .rd_in(ext_rd_out),
    .wr_in(ext_wr_out), .page_in(ext_page_out), .addr_in(ext_addr_out),
    .wdata_in(ext_wdata_out), .rdata_out(ext_rd_data_in));
  // clock of 25 ns
  always #12.5 mclk_in = ~mclk_in;
  // random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // reference map of reserved and banked places
  function automatic logic rsv(input logic [7:0] a);
    return (a inside {8'h9d, 8'h9e, 8'ha1, 8'hb6}) ||
      (pg && a inside {8'hef, 8'hf5, 8'hf6, 8'hf7, 8'hfd, 8'hfe, 8'hff});
  endfunction
  function automatic logic [8:0] key(input logic [7:0] a);
    return (a inside {8'hf4, [8'hf8:8'hfc]}) ? {1'b0, a} : {pg, a};
  endfunction
  function automatic logic [7:0] expv(input logic [7:0] a);
    if (a == 8'h91)
      return {7'h00, pg};
    if (a == 8'hc7 || rsv(a))
      return 8'h00;
    return (a == 8'hf4) ? (mm[key(a)] & 8'hfc) : mm[key(a)];
  endfunction
  // one request held for one edge
  task automatic op(input logic r, w, b, input logic [7:0] a, d,
                    input logic [2:0] bs = 3'h0, input logic v = 1'b0);
    @(posedge mclk_in);
    {rd_in, wr_in, bit_in, bit_sel_in, bit_val_in} <= {r, w, b, bs, v};
    sfr_addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    {rd_in, wr_in, bit_in} <= 3'h0;
    if (w && !b && direct_in && !rsv(a) && a != 8'h91 && a != 8'hc7)
      mm[key(a)] = d;
  endtask
  // byte read compared with the reference
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = expv(a);
    op(1'b1, 1'b0, 1'b0, a, 8'h00);
    @(posedge mclk_in);
    #1 `CHK(rd_valid_out, direct_in)
    if (direct_in)
      `CHK(rd_data_out, e)
  endtask
  // key pair then selector write, three accesses back to back
  task automatic unlock(input logic [7:0] d);
    @(posedge mclk_in);
    {rd_in, wr_in, bit_in} <= 3'b010;
    sfr_addr_in <= 8'hc7;
    wdata_in <= 8'haa;
    @(posedge mclk_in);
    wdata_in <= 8'h55;
    @(posedge mclk_in);
    sfr_addr_in <= 8'h91;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    pg = d[0];
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge mclk_in);
    failures++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    foreach (mm[i])
      mm[i] = 8'h00;
    repeat (10) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    #1 `CHK(page_out, 1'b0)
    rd_chk(8'h91);
    for (int i = 3; i < 16; i++)
      if (i != 13)
        rd_chk(8'hf0 + 8'(i));
    op(1'b0, 1'b1, 1'b0, 8'h91, 8'h01);
    #1 `CHK(page_out, 1'b0)
    unlock(8'h01);
    #1 `CHK(page_out, 1'b1)
    op(1'b0, 1'b1, 1'b0, 8'hf3, 8'h5a);
    op(1'b0, 1'b1, 1'b0, 8'hf8, 8'h3c);
    #1 `CHK(spi_control_ext_out, 8'h5a)
    rd_chk(8'hf3);
    rd_chk(8'hf5);
    unlock(8'h00);
    rd_chk(8'hf3);
    rd_chk(8'hf8);
    op(1'b0, 1'b1, 1'b1, 8'hf8, 8'h00, 3'h7, 1'b1);
    mm[9'h0f8][7] = 1'b1;
    rd_chk(8'hf8);
    op(1'b1, 1'b0, 1'b1, 8'hf8, 8'h00, 3'h7);
    @(posedge mclk_in);
    #1 `CHK(bit_rd_out, 1'b1)
    op(1'b0, 1'b1, 1'b1, 8'hf9, 8'h00, 3'h1, 1'b1);
    #1 `CHK(bit_refused_out, 1'b1)
    rd_chk(8'hf9);
    @(posedge mclk_in);
    direct_in <= 1'b0;
    op(1'b0, 1'b1, 1'b0, 8'hf8, 8'h77);
    rd_chk(8'hf8);
    direct_in <= 1'b1;
    rd_chk(8'hf8);
    rd_chk(8'h9d);
    for (int i = 0; i < 24; i++) begin
      s = xs(s);
      sfr_addr_in <= s[4] ? 8'hf8 + 8'(s[2:0] % 3'd5) : {4'h8, s[3:0]};
      op(1'b0, 1'b1, 1'b0, s[4] ? 8'hf8 + 8'(s[2:0] % 3'd5) :
         {4'h8, s[3:0]}, s[15:8]);
      rd_chk(s[4] ? 8'hf8 + 8'(s[2:0] % 3'd5) : {4'h8, s[3:0]});
    end
    tally_and_finish;
  end
endmodule
